// ### uhig_cfg.svh
`ifndef UHIG_CFG_SVH
`define UHIG_CFG_SVH

`define UHIG_ADDR_INT_CFG      8'h10
`define UHIG_ADDR_INT_EN       8'h14

`define UHIG_EN_RESET          32'h0000_0000
`define UHIG_EN_VALID_MASK     32'h03FF_FD7F
`define UHIG_EN_BUSRST_KEEP    32'h0000_0001
`define UHIG_EN_BRST_BIT       0
`define UHIG_EN_SETUP_BIT      8
`define UHIG_EN_EP_BASE        10
`define UHIG_SRC_WIDTH         26
`define UHIG_BUS_EVENTS        7

`define UHIG_CFG_RESET         8'hFC
`define UHIG_CFG_FIELDS_BUSRST 6'h3F
`define UHIG_CFG_CTRL_LSB      6
`define UHIG_CFG_IN_LSB        4
`define UHIG_CFG_OUT_LSB       2
`define UHIG_CFG_LVL_BIT       1
`define UHIG_CFG_POL_BIT       0

`define UHIG_CLK_PERIOD_NS     100
`define UHIG_PULSE_NS          60
`define UHIG_PULSE_RAW         ((`UHIG_PULSE_NS + `UHIG_CLK_PERIOD_NS - 1) / `UHIG_CLK_PERIOD_NS)
`define UHIG_PULSE_CYCLES      ((`UHIG_PULSE_RAW < 1) ? 1 : `UHIG_PULSE_RAW)

`endif

// ### uhig_pkg.sv
package uhig_pkg;

	typedef enum logic [1:0] {
		HS_ACK  = 2'b00,
		HS_NAK  = 2'b01,
		HS_NYET = 2'b10,
		HS_STALL = 2'b11
	} uhig_hs_code_t;

	typedef struct packed {
		logic          valid;
		logic [2:0]    ep;
		logic          dir_in;
		logic          setup;
		uhig_hs_code_t code;
	} uhig_hs_event_t;

endpackage

// ### uhig_hs_qualify.sv
`timescale 1ns/1ps
`include "uhig_cfg.svh"

module uhig_hs_qualify (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    bus_reset,
	input  wire uhig_pkg::uhig_hs_event_t hs,
	input  wire logic [1:0]              ctrl_ep_handshake_irq_sel,
	input  wire logic [1:0]              in_ep_handshake_irq_sel,
	input  wire logic [1:0]              out_ep_handshake_irq_sel,
	output logic [`UHIG_SRC_WIDTH-1:0]   hs_src
);
	import uhig_pkg::*;

	logic        acked [16];
	logic [3:0]  slot;
	logic [1:0]  sel;
	logic        data_out;
	logic        hit;

	function automatic logic qualifies(input logic [1:0] s, input uhig_hs_code_t c,
			input logic is_data_out, input logic prior_ack);
		case (c)
			HS_ACK:  qualifies = 1'b1;
			HS_NYET: qualifies = is_data_out;
			HS_NAK:  qualifies = (s == 2'b00) | (s[1] & prior_ack);
			default: qualifies = 1'b0;
		endcase
	endfunction

	function automatic logic [4:0] src_bit(input logic [2:0] ep, input logic dir_in, input logic setup);
		if (ep == 3'h0 && setup) begin
			src_bit = 5'(`UHIG_EN_SETUP_BIT);
		end else begin
			src_bit = 5'({1'b0, ep, dir_in}) + 5'(`UHIG_EN_EP_BASE);
		end
	endfunction

	assign slot     = {hs.ep, hs.dir_in};
	assign data_out = (hs.ep != 3'h0) && !hs.dir_in;

	always_comb begin
		if (hs.ep == 3'h0) begin
			sel = ctrl_ep_handshake_irq_sel;
		end else if (hs.dir_in) begin
			sel = in_ep_handshake_irq_sel;
		end else begin
			sel = out_ep_handshake_irq_sel;
		end
	end

	assign hit = hs.valid & qualifies(sel, hs.code, data_out, acked[slot]);

	always_comb begin
		hs_src = '0;
		if (hit) begin
			hs_src[src_bit(hs.ep, hs.dir_in, hs.setup)] = 1'b1;
		end
	end

	// Any NAK clears the history, so only the first NAK after an ACK or NYET counts.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				acked[i] <= 1'b0;
			end
		end else if (bus_reset) begin
			for (int i = 0; i < 16; i++) begin
				acked[i] <= 1'b0;
			end
		end else if (hs.valid) begin
			if (hs.code == HS_ACK || hs.code == HS_NYET) begin
				acked[slot] <= 1'b1;
			end else if (hs.code == HS_NAK) begin
				acked[slot] <= 1'b0;
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	AST_FIRST_NAK_ONLY: assert property (
		(hs.valid && hs.code == HS_NAK && sel[1] && !acked[slot]) |-> (hs_src == '0))
		else $error("NAK without prior ACK raised an interrupt");
	AST_NO_EVENT_NO_SRC: assert property (
		!hs.valid |-> (hs_src == '0))
		else $error("Handshake source without a handshake");
	AST_REPEAT_NAK: assert property (
		(hs.valid && hs.code == HS_NAK && sel[1]) ##1 (hs.valid && hs.code == HS_NAK && slot == $past(slot))
		|-> (hs_src == '0))
		else $error("Second consecutive NAK raised an interrupt");
	COV_FIRST_NAK: cover property (hs.valid && hs.code == HS_NAK && sel[1] && hit);
endmodule

// ### uhig_usb_handshake_interrupt_gate.sv
`timescale 1ns/1ps
`include "uhig_cfg.svh"

// Behaviour
// - Endpoint 0 handshakes filtered by control select: all, ACK only, ACK plus first NAK.
// - Data IN handshakes on endpoints 1-7 filtered by the IN select, same choices.
// - Data OUT filtered by OUT select, NYET counted alongside ACK.
// - Endpoint 0 IN, OUT and SETUP use the control select, never data selects.
// - First NAK means the first NAK after an ACK or NYET; repeats are silent.
// - Handshake interrupt only on an actual ACK, NAK or data OUT NYET that qualifies.
// - Enable bits 25..12 gate endpoints 1-7, transmit above receive, endpoint 7 on top.
// - Bit 11 enables control IN, bit 10 control OUT.
// - Bit 8 enables setup received; bit 9 reserved.
// - Bits 6..0 gate DMA, high-speed, resume, suspend, pseudo SOF, SOF, bus reset.
// - USB bus reset clears all enables except bus reset enable bit 0.
// - Global enable low suppresses every interrupt.
// - Global enable high lets enabled sources reach the output.
// - Pulse select high gives a short pulse per interrupt, low gives a level.
module uhig_usb_handshake_interrupt_gate (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       usb_bus_reset,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	input  wire logic [3:0]                 reg_be,
	input  wire logic [31:0]                reg_wdata,
	output logic [31:0]                     reg_rdata,
	input  wire uhig_pkg::uhig_hs_event_t   hs,
	input  wire logic [`UHIG_BUS_EVENTS-1:0] bus_event,
	input  wire logic                       global_irq_en,
	input  wire logic                       irq_clear,
	output logic                            int_pin,
	output logic [`UHIG_SRC_WIDTH-1:0]      irq_source,
	output logic                            irq_pending
);
	import uhig_pkg::*;

	logic [31:0]                 int_en;
	logic [7:0]                  int_cfg;
	logic [`UHIG_SRC_WIDTH-1:0]  hs_src;
	logic [`UHIG_SRC_WIDTH-1:0]  raw_src;
	logic [`UHIG_SRC_WIDTH-1:0]  gated_src;
	logic                        any_gated;
	logic [1:0]                  pulse_cnt;
	logic                        active;
	logic [31:0]                 next_int_en;
	logic                        ctrl_in_irq_en;
	logic                        ctrl_out_irq_en;
	logic                        setup_packet_irq_en;
	logic                        bus_reset_irq_en;
	logic                        irq_pulse_select;
	logic                        irq_polarity;

	localparam logic [1:0] PULSE_LOAD = 2'(`UHIG_PULSE_CYCLES);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		merge_bytes = res;
	endfunction

	assign ctrl_in_irq_en      = int_en[`UHIG_EN_EP_BASE + 1];
	assign ctrl_out_irq_en     = int_en[`UHIG_EN_EP_BASE];
	assign setup_packet_irq_en = int_en[`UHIG_EN_SETUP_BIT];
	assign bus_reset_irq_en    = int_en[`UHIG_EN_BRST_BIT];
	assign irq_pulse_select    = int_cfg[`UHIG_CFG_LVL_BIT];
	assign irq_polarity        = int_cfg[`UHIG_CFG_POL_BIT];

	uhig_hs_qualify u_qualify (
		.clk                       (clk),
		.rst                       (rst),
		.bus_reset                 (usb_bus_reset),
		.hs                        (hs),
		.ctrl_ep_handshake_irq_sel (int_cfg[`UHIG_CFG_CTRL_LSB +: 2]),
		.in_ep_handshake_irq_sel   (int_cfg[`UHIG_CFG_IN_LSB +: 2]),
		.out_ep_handshake_irq_sel  (int_cfg[`UHIG_CFG_OUT_LSB +: 2]),
		.hs_src                    (hs_src)
	);

	// Bus events occupy the low bits, so one mask serves both kinds of source.
	assign raw_src   = hs_src | {{(`UHIG_SRC_WIDTH - `UHIG_BUS_EVENTS){1'b0}}, bus_event};
	assign gated_src = raw_src & int_en[`UHIG_SRC_WIDTH-1:0];
	assign any_gated = (|gated_src) & global_irq_en;

	// Reserved bits are forced to zero so a careless write cannot enable a phantom source.
	assign next_int_en = merge_bytes(int_en, reg_wdata, reg_be) & `UHIG_EN_VALID_MASK;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_en <= `UHIG_EN_RESET;
		end else if (usb_bus_reset) begin
			int_en <= int_en & `UHIG_EN_BUSRST_KEEP;
		end else if (reg_wr && reg_addr == `UHIG_ADDR_INT_EN) begin
			int_en <= next_int_en;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_cfg <= `UHIG_CFG_RESET;
		end else if (usb_bus_reset) begin
			int_cfg <= {`UHIG_CFG_FIELDS_BUSRST, int_cfg[1:0]};
		end else if (reg_wr && reg_addr == `UHIG_ADDR_INT_CFG && reg_be[0]) begin
			int_cfg <= reg_wdata[7:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`UHIG_ADDR_INT_EN:  reg_rdata <= int_en;
				`UHIG_ADDR_INT_CFG: reg_rdata <= {24'h00_0000, int_cfg};
				default:            reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_source <= '0;
		end else begin
			irq_source <= global_irq_en ? gated_src : '0;
		end
	end

	// A new event in the clearing cycle keeps the interrupt pending.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_pending <= 1'b0;
		end else if (any_gated) begin
			irq_pending <= 1'b1;
		end else if (irq_clear) begin
			irq_pending <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulse_cnt <= 2'h0;
		end else if (any_gated) begin
			pulse_cnt <= PULSE_LOAD;
		end else if (pulse_cnt != 2'h0) begin
			pulse_cnt <= pulse_cnt - 2'h1;
		end
	end

	// The pulse cannot be shorter than one clock period, so it stretches to a full cycle.
	assign active = global_irq_en & (irq_pulse_select ? (pulse_cnt != 2'h0) : irq_pending);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_pin <= 1'b1;
		end else begin
			int_pin <= irq_polarity ? active : ~active;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	AST_GLOBAL_OFF: assert property (
		!global_irq_en |=> (int_pin == !$past(irq_polarity)))
		else $error("Interrupt output active with global enable low");
	AST_BUSRST_CLEAR: assert property (
		usb_bus_reset |=> ((int_en & ~`UHIG_EN_BUSRST_KEEP) == 32'h0000_0000))
		else $error("Bus reset left an enable set");
	AST_BUSRST_KEEP: assert property (
		usb_bus_reset |=> (bus_reset_irq_en == $past(bus_reset_irq_en)))
		else $error("Bus reset changed the bus reset enable");
	AST_RSVD_ZERO: assert property (
		(int_en & ~`UHIG_EN_VALID_MASK) == 32'h0000_0000)
		else $error("Reserved enable bit set");
	AST_SRC_GATED: assert property (
		(|irq_source) |-> ((irq_source & ~$past(int_en[`UHIG_SRC_WIDTH-1:0])) == '0))
		else $error("Disabled source reported");
	AST_PULSE_SHAPE: assert property (
		(irq_pulse_select && global_irq_en && any_gated) ##1 (irq_pulse_select && global_irq_en && !any_gated)
		|=> (int_pin == irq_polarity) ##1 (int_pin == !irq_polarity))
		else $error("Pulse mode output not one cycle wide");
	AST_LEVEL_HOLD: assert property (
		(!irq_pulse_select && global_irq_en && irq_pending) |=> (int_pin == $past(irq_polarity)))
		else $error("Level interrupt not shown");
	AST_CTRL_ACK_ONLY: assert property (
		(hs.valid && hs.ep == 3'h0 && hs.code == HS_NAK && int_cfg[`UHIG_CFG_CTRL_LSB +: 2] == 2'b01)
		|-> (hs_src == '0))
		else $error("Control NAK raised in ACK-only setting");
	AST_IN_ACK_ONLY: assert property (
		(hs.valid && hs.ep != 3'h0 && hs.dir_in && hs.code == HS_NAK && int_cfg[`UHIG_CFG_IN_LSB +: 2] == 2'b01)
		|-> (hs_src == '0))
		else $error("Data IN NAK raised in ACK-only setting");
	AST_OUT_NYET: assert property (
		(hs.valid && hs.ep != 3'h0 && !hs.dir_in && hs.code == HS_NYET)
		|-> (hs_src[`UHIG_EN_EP_BASE + 2 * hs.ep] == 1'b1))
		else $error("Data OUT NYET not raised");
	AST_EP0_SETUP: assert property (
		(hs.valid && hs.ep == 3'h0 && hs.setup && hs.code == HS_ACK) |-> hs_src[`UHIG_EN_SETUP_BIT])
		else $error("Setup ACK not routed to setup source");
	AST_EP0_GATED: assert property (
		(irq_source[`UHIG_EN_EP_BASE + 1] |-> $past(ctrl_in_irq_en))
		and (irq_source[`UHIG_EN_EP_BASE] |-> $past(ctrl_out_irq_en))
		and (irq_source[`UHIG_EN_SETUP_BIT] |-> $past(setup_packet_irq_en)))
		else $error("Endpoint 0 source reported while disabled");

	COV_LEVEL_IRQ: cover property (!irq_pulse_select && any_gated ##1 irq_pending ##[1:4] irq_clear);
	COV_PULSE_IRQ: cover property (irq_pulse_select && any_gated);
	COV_BUSRST: cover property (bus_reset_irq_en && usb_bus_reset);
endmodule

// ### uhig_host.sv
`timescale 1ns/1ps
`include "uhig_cfg.svh"

module uhig_host (
	input  wire logic        clk,
	output logic [7:0]       reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [3:0]       reg_be,
	output logic [31:0]      reg_wdata,
	input  wire logic [31:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_be = 4'hF;
		reg_wdata = 32'h0000_0000;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= (a == `UHIG_ADDR_INT_EN) ? (d & 32'h03FF_FFFF) : d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// A released bus shows the inverse so stale data is never mistaken for a write.
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		q = reg_rdata;
	endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
`include "uhig_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end

module tb;
	import uhig_pkg::*;
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  usb_bus_reset = 1'b0;
	logic [7:0]            reg_addr;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [3:0]            reg_be;
	logic [31:0]           reg_wdata;
	logic [31:0]           reg_rdata;
	uhig_hs_event_t        hs;
	logic [6:0]            bus_event;
	logic                  global_irq_en;
	logic                  irq_clear;
	logic                  int_pin;
	logic [25:0]           irq_source;
	logic                  irq_pending;
	int                    failures = 0;
	int                    n_checks = 0;
	logic [31:0]           seed = 32'hE64D06A7;
	logic [31:0]           en;
	logic [31:0]           q;
	logic [31:0]           r;
	logic [7:0]            cfg;
	logic                  hist [8][2];
	uhig_hs_event_t        h;
	logic [6:0]            ev;
	logic                  clr;
	logic [25:0]           s;
	logic [25:0]           es;
	logic                  epend;

	always #50 clk = ~clk;

	uhig_host HOST (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	uhig_usb_handshake_interrupt_gate DUT (.clk(clk), .rst(rst), .usb_bus_reset(usb_bus_reset),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .hs(hs), .bus_event(bus_event), .global_irq_en(global_irq_en),
		.irq_clear(irq_clear), .int_pin(int_pin), .irq_source(irq_source), .irq_pending(irq_pending));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Updates the per-endpoint history, so it must be called once per driven event.
	function automatic logic [25:0] predict(uhig_hs_event_t e, logic [6:0] v);
		logic [25:0] t;
		logic [1:0]  sel;
		logic        nak;
		logic        ok;
		t = {19'h0, v};
		sel = (e.ep == 3'd0) ? cfg[7:6] : (e.dir_in ? cfg[5:4] : cfg[3:2]);
		nak = (e.code == HS_NAK);
		ok = (e.code == HS_ACK) || (e.code == HS_NYET && e.ep != 3'd0 && !e.dir_in);
		if (nak) begin
			ok = (sel == 2'b00) || (sel[1] && hist[e.ep][e.dir_in]);
		end
		if (e.valid && ok) begin
			t[(e.setup && e.ep == 3'd0) ? 8 : 10 + 2 * e.ep + e.dir_in] = 1'b1;
		end
		if (e.valid && e.code != HS_STALL) begin
			hist[e.ep][e.dir_in] = !nak;
		end
		return t & en[25:0] & {26{global_irq_en}};
	endfunction

	task automatic ev_pulse(input logic [6:0] v, input logic c);
		@(posedge clk);
		bus_event <= v;
		irq_clear <= c;
		@(posedge clk);
		bus_event <= 7'h00;
		irq_clear <= 1'b0;
		@(negedge clk);
	endtask

	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		failures++;
		finish_test();
	end

	initial begin
		hs = '0;
		bus_event = 7'h00;
		global_irq_en = 1'b1;
		irq_clear = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK(int_pin, 1'b1)
		HOST.rd(`UHIG_ADDR_INT_EN, q);
		`CHK(q, 32'h0000_0000)
		HOST.rd(`UHIG_ADDR_INT_CFG, q);
		`CHK(q[7:0], 8'hFC)
		HOST.rd(8'h04, q);
		`CHK(q, 32'h0000_0000)
		$display("test reset done");
		foreach (hist[i, j]) hist[i][j] = 1'b0;
		es = '0;
		epend = 1'b0;
		for (int b = 0; b < 8; b++) begin
			cfg = {b[1:0], b[1:0] + 2'd1, b[1:0] + 2'd2, 2'b00};
			en = rnd();
			HOST.wr(`UHIG_ADDR_INT_CFG, {24'h0, cfg});
			HOST.wr(`UHIG_ADDR_INT_EN, en);
			en = en & `UHIG_EN_VALID_MASK;
			HOST.rd(`UHIG_ADDR_INT_EN, q);
			`CHK(q, en)
			for (int k = 0; k <= 300; k++) begin
				r = (k == 300) ? 32'h0000_0000 : rnd();
				h.valid = |r[1:0];
				h.ep = r[4:2];
				h.setup = (r[4:2] == 3'd0) && r[6];
				h.dir_in = r[5] && !h.setup;
				h.code = h.setup ? HS_ACK : uhig_hs_code_t'(r[9:8]);
				ev = (r[31:29] == 3'd0) ? r[18:12] : 7'h00;
				clr = (r[28:26] == 3'd1);
				@(posedge clk);
				hs <= h;
				bus_event <= ev;
				irq_clear <= clr;
				s = predict(h, ev);
				@(negedge clk);
				`CHK(irq_source, es)
				`CHK(irq_pending, epend)
				es = s;
				epend = (|s) | (epend & ~clr);
			end
		end
		$display("test random done");
		HOST.wr(`UHIG_ADDR_INT_EN, 32'hFFFF_FFFF);
		HOST.wr(`UHIG_ADDR_INT_CFG, 32'h0000_0003);
		@(posedge clk);
		usb_bus_reset <= 1'b1;
		@(posedge clk);
		usb_bus_reset <= 1'b0;
		HOST.rd(`UHIG_ADDR_INT_EN, q);
		`CHK(q, 32'h0000_0001)
		HOST.rd(`UHIG_ADDR_INT_CFG, q);
		`CHK(q[7:0], 8'hFF)
		$display("test bus reset done");
		HOST.wr(`UHIG_ADDR_INT_EN, 32'h0000_0002);
		ev_pulse(7'h02, 1'b0);
		`CHK(irq_source, 26'h2)
		@(negedge clk);
		`CHK(int_pin, 1'b1)
		@(negedge clk);
		`CHK(int_pin, 1'b0)
		HOST.wr(`UHIG_ADDR_INT_CFG, 32'h0000_0001);
		ev_pulse(7'h02, 1'b1);
		repeat (3) @(negedge clk);
		`CHK(int_pin, 1'b1)
		ev_pulse(7'h00, 1'b1);
		@(negedge clk);
		`CHK(int_pin, 1'b0)
		@(posedge clk);
		global_irq_en <= 1'b0;
		ev_pulse(7'h7F, 1'b0);
		`CHK(irq_source, 26'h0)
		@(negedge clk);
		`CHK(irq_pending, 1'b0)
		`CHK(int_pin, 1'b0)
		@(posedge clk);
		global_irq_en <= 1'b1;
		HOST.wr(`UHIG_ADDR_INT_CFG, 32'h0000_0002);
		ev_pulse(7'h02, 1'b0);
		`CHK(int_pin, 1'b1)
		@(negedge clk);
		`CHK(int_pin, 1'b0)
		@(negedge clk);
		`CHK(int_pin, 1'b1)
		$display("test output done");
		finish_test();
	end
endmodule
